// File: design/hex_float_defines.svh
// Field positions, widths and constants of the base-16 float operand formats
`ifndef HEX_FLOAT_DEFINES_SVH
`define HEX_FLOAT_DEFINES_SVH
`define HF_WORD_W 64
`define HF_SGL_W 32
`define HF_EXP_W 7
`define HF_EXP_BIAS 7'h40
`define HF_MANT_SGL_W 24
`define HF_MANT_DBL_W 56
`define HF_GUARD_W 8
`define HF_RND_BIT 8
`define HF_FSR_W 32
`define HF_FSR_RST 32'h0000_0000
`define HF_NORM_STEPS 16
`endif

// File: design/hex_float_operand_prep.sv
// Operand preparation front end of a base-16 floating-point unit
//
// Behaviour
// RULE_01 - Operands are 32-bit single or 64-bit double, sign-magnitude.
// RULE_02 - Top bit is the mantissa sign: 0 positive, 1 negative.
// RULE_03 - Exponent is unsigned, biased by 64.
// RULE_04 - Exponent lies in bits 1-7; load exponent copies fixed bits 17-23.
// RULE_05 - Mantissa is a fraction with binary point between bits 7 and 8.
// RULE_06 - Normalized mantissa ranges from 1/16 to just below one.
// RULE_07 - A zero mantissa means the whole operand is true zero.
// RULE_08 - Issuer supplies normalized operands except for moves, normalize, read-high.
// RULE_09 - Read high copies float bits 0-15 to fixed bits 16-31.
// RULE_10 - Single ops use accumulator bits 0-31, ignoring 32-63.
// RULE_11 - Single results go to the upper half; lower 32 bits cleared.
// RULE_12 - Steps: guard, align, compute and normalize, round, store.
// RULE_13 - Guard digits are zeroed hex digits below the mantissa.
// RULE_14 - One guard digit when round flag clear, two when set; the flag masks operand a only, before alignment.
// RULE_15 - Round flag is written by the load float status operation.
// RULE_16 - Integerize, scale, wide fix/float, single store ignore round flag.
// RULE_17 - Flag clear truncates the guard digit; set rounds on two.
// RULE_18 - Normalize shifts left by hex digits, decrementing exponent.
// RULE_19 - Mantissa spans bits 8-31 single, 8-63 double.
//
// Bit 0 is the most significant bit of each operand word.
`timescale 1ns/1ps
`include "hex_float_defines.svh"
module hex_float_operand_prep
    import hex_float_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_start,
    input wire fop_e i_op,
    input wire logic i_single,
    input wire logic [63:0] i_acc_a,
    input wire logic [63:0] i_acc_b,
    input wire logic [31:0] i_fixed_acc,
    input wire logic [31:0] i_status_wdata,
    input wire logic [63:0] i_core_result,
    input wire logic [6:0] i_core_exp,
    input wire logic i_core_done,
    output logic o_core_start,
    output logic [63:0] o_core_mant_a,
    output logic [63:0] o_core_mant_b,
    output logic [6:0] o_core_exp,
    output logic [1:0] o_core_sign,
    output logic o_result_valid,
    output logic [63:0] o_result,
    output logic o_fixed_valid,
    output logic [31:0] o_fixed_result,
    output logic [31:0] o_float_status,
    output logic o_busy,
    output logic o_true_zero_err
);
    ////////////////////////////////////////////////////////////////////////
    step_e step_q;
    fop_e op_q;
    logic single_q;
    logic round_q;
    logic sign_q;
    logic [31:0] fsr_q;
    logic [63:0] a_q;
    logic [63:0] b_q;
    logic [63:0] ma_q;
    logic [63:0] mb_q;
    logic [6:0] exp_q;
    logic [55:0] nr_mant;
    logic [6:0] nr_exp;

    // Operand view: single ignores the low half
    function automatic logic [63:0] view(input logic [63:0] w, input logic sgl);
        view = sgl ? {w[63:32], 32'h0} : w; // RULE_10 RULE_01
    endfunction
    // Mantissa field left-justified, with zero guard room below it
    function automatic logic [63:0] mant_of(input logic [63:0] w);
        mant_of = {w[55:0], 8'h00}; // RULE_19 RULE_05 RULE_13
    endfunction
    // Zero mantissa with nonzero sign or exponent breaks the true-zero form
    function automatic logic bad_zero(input logic [63:0] w);
        bad_zero = (w[55:0] == 56'h0) && (w[63:56] != 8'h00); // RULE_07
    endfunction
    // Guard mask: one hex digit or two
    function automatic logic [63:0] guard_mask(input logic rnd, input logic sgl);
        logic [63:0] m;
        m = rnd ? 64'hffff_ffff_ffff_ffff : 64'hffff_ffff_ffff_fff0; // RULE_14
        guard_mask = sgl ? (rnd ? 64'hffff_ffff_0000_0000 : 64'hffff_fff0_0000_0000) & m
                         : m;
    endfunction

    hex_norm_round u_norm (
        .i_mant(i_core_result),
        .i_exp(i_core_exp),
        .i_round(round_q),
        .i_single(single_q),
        .o_mant(nr_mant),
        .o_exp(nr_exp)
    );

    ////////////////////////////////////////////////////////////////////////
    // Float status register
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            fsr_q <= `HF_FSR_RST;
        end else if (i_start && !o_busy && i_op == OP_LOAD_STATUS) begin
            fsr_q <= i_status_wdata; // RULE_15
        end
    end
    assign o_float_status = fsr_q;

    ////////////////////////////////////////////////////////////////////////
    // Step sequencer
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            step_q <= ST_IDLE;
            op_q <= OP_NONE;
            single_q <= 1'b0;
            round_q <= 1'b0;
            a_q <= 64'h0;
            b_q <= 64'h0;
        end else begin
            unique case (step_q)
                ST_IDLE: begin
                    if (i_start && i_op inside {OP_ADD, OP_SUB, OP_MUL, OP_DIV,
                                                OP_NORMALIZE}) begin
                        step_q <= ST_GUARD;
                        op_q <= i_op;
                        single_q <= i_single;
                        a_q <= view(i_acc_a, i_single);
                        b_q <= view(i_acc_b, i_single);
                        round_q <= fsr_q[31 - `HF_RND_BIT]; // RULE_14
                    end
                end
                ST_GUARD: step_q <= (op_q inside {OP_ADD, OP_SUB}) ? ST_ALIGN : ST_NORM; // RULE_12
                ST_ALIGN: step_q <= ST_NORM;
                ST_NORM: begin
                    if (i_core_done) begin
                        step_q <= ST_ROUND;
                    end
                end
                ST_ROUND: step_q <= ST_STORE;
                ST_STORE: step_q <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Guard append and alignment of mantissas toward the core
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            ma_q <= 64'h0;
            mb_q <= 64'h0;
            exp_q <= 7'h00;
            sign_q <= 1'b0;
            o_core_sign <= 2'b00;
        end else if (step_q == ST_GUARD) begin
            ma_q <= mant_of(a_q) & guard_mask(round_q, single_q); // RULE_13
            mb_q <= mant_of(b_q) & guard_mask(1'b0, single_q) & {8'hff, 56'h0} | mant_of(b_q)
                    & 64'hffff_ffff_ffff_ff00;
            exp_q <= a_q[62:56]; // RULE_03 RULE_04
            o_core_sign <= {a_q[63], b_q[63] ^ (op_q == OP_SUB)}; // RULE_02
        end else if (step_q == ST_ALIGN) begin
            // Shift the smaller-exponent mantissa right by the exponent gap
            if (a_q[62:56] >= b_q[62:56]) begin
                mb_q <= (a_q[62:56] - b_q[62:56] > 7'd15) ? 64'h0
                        : mb_q >> {a_q[62:56] - b_q[62:56], 2'b00};
            end else begin
                ma_q <= (b_q[62:56] - a_q[62:56] > 7'd15) ? 64'h0
                        : ma_q >> {b_q[62:56] - a_q[62:56], 2'b00};
                exp_q <= b_q[62:56];
            end
        end else if (step_q == ST_ROUND) begin
            // Zero results are positive; otherwise products and quotients carry a xor b and sums keep the sign of operand a
            if (nr_mant == 56'h0) begin
                sign_q <= 1'b0;
            end else if (op_q inside {OP_MUL, OP_DIV}) begin
                sign_q <= o_core_sign[1] ^ o_core_sign[0]; // RULE_02
            end else begin
                sign_q <= o_core_sign[1];
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_core_start <= 1'b0;
        end else begin
            o_core_start <= (step_q == ST_GUARD && !(op_q inside {OP_ADD, OP_SUB}))
                            || step_q == ST_ALIGN;
        end
    end
    // Operands leave the guard and align flops directly, so they are final with the start pulse
    assign o_core_mant_a = ma_q;
    assign o_core_mant_b = mb_q;
    assign o_core_exp = exp_q;

    ////////////////////////////////////////////////////////////////////////
    // Results: float store, direct conversions and fixed-point outputs
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_result_valid <= 1'b0;
            o_result <= 64'h0;
            o_fixed_valid <= 1'b0;
            o_fixed_result <= 32'h0;
            o_true_zero_err <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            o_result_valid <= 1'b0;
            o_fixed_valid <= 1'b0;
            o_busy <= (step_q != ST_IDLE && step_q != ST_STORE) || (step_q == ST_IDLE
                      && i_start && i_op inside {OP_ADD, OP_SUB, OP_MUL, OP_DIV,
                                                 OP_NORMALIZE});
            if (step_q == ST_STORE) begin
                o_result_valid <= 1'b1; // RULE_12
                o_result <= {sign_q, nr_exp, nr_mant}; // RULE_06
                if (single_q) begin
                    o_result[31:0] <= 32'h0; // RULE_11
                end
            end else if (step_q == ST_IDLE && i_start) begin
                o_true_zero_err <= bad_zero(view(i_acc_a, i_single))
                                   || bad_zero(view(i_acc_b, i_single));
                unique case (i_op)
                    OP_LOAD_EXP: begin
                        o_result_valid <= 1'b1;
                        o_result <= {i_acc_a[63], i_fixed_acc[14:8],
                                     i_acc_a[55:0]}; // RULE_04
                    end
                    OP_READ_HIGH: begin
                        o_fixed_valid <= 1'b1;
                        o_fixed_result <= {16'h0, i_acc_a[63:48]}; // RULE_09
                    end
                    OP_LOAD, OP_STORE, OP_SINGLE_STORE, OP_INTEGERIZE, OP_SCALE,
                    OP_WIDE_FIX, OP_WIDE_FLOAT: begin
                        // Passed through unrounded, flag not consulted
                        o_result_valid <= 1'b1; // RULE_16
                        o_result <= view(i_acc_a, i_single); // RULE_08
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule

// File: design/hex_float_pkg.sv
// Types shared by the float operand preparation block
package hex_float_pkg;
    typedef enum logic [3:0] {
        OP_NONE,
        OP_ADD,
        OP_SUB,
        OP_MUL,
        OP_DIV,
        OP_LOAD,
        OP_STORE,
        OP_NORMALIZE,
        OP_READ_HIGH,
        OP_LOAD_EXP,
        OP_INTEGERIZE,
        OP_SCALE,
        OP_WIDE_FIX,
        OP_WIDE_FLOAT,
        OP_SINGLE_STORE,
        OP_LOAD_STATUS
    } fop_e;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_GUARD,
        ST_ALIGN,
        ST_NORM,
        ST_ROUND,
        ST_STORE
    } step_e;
endpackage

// File: design/hex_norm_round.sv
// Hex-digit normalizer and truncate/round stage of the float datapath
`timescale 1ns/1ps
`include "hex_float_defines.svh"
module hex_norm_round (
    input wire logic [63:0] i_mant,
    input wire logic [6:0] i_exp,
    input wire logic i_round,
    input wire logic i_single,
    output logic [55:0] o_mant,
    output logic [6:0] o_exp
);
    logic [63:0] m;
    logic [6:0] e;
    logic [7:0] grd;
    logic [56:0] sum;
    always_comb begin
        m = i_mant;
        e = i_exp;
        // Shift left one hex digit per step until top digit nonzero
        for (int i = 0; i < `HF_NORM_STEPS; i++) begin
            if (m != 64'h0 && m[63:60] == 4'h0) begin // RULE_18
                m = {m[59:0], 4'h0};
                e = e - 7'h01;
            end
        end
        if (i_single) begin
            grd = m[39:32];
            m[31:0] = 32'h0;
        end else begin
            grd = m[7:0];
        end
        sum = {1'b0, m[63:8]};
        if (i_single) begin
            sum[31:0] = 32'h0;
        end
        if (i_round) begin // RULE_17
            if (grd == 8'h80) begin
                sum = sum + (i_single ? {24'h0, m[40], 32'h0} : {56'h0, m[8]});
            end else if (grd > 8'h80) begin
                sum = sum + (i_single ? {25'h1, 32'h0} : 57'h1);
            end
        end
        if (sum[56]) begin
            sum = {1'b0, 4'h1, sum[55:4]};
            e = e + 7'h01;
        end
        if (i_single) begin
            sum[31:0] = 32'h0;
        end
        o_mant = sum[55:0];
        o_exp = (o_mant == 56'h0) ? 7'h00 : e;
    end
endmodule

// File: tb/hex_float_operand_prep_tb_top.sv
// Self-checking bench of the float operand preparation block
`timescale 1ns/1ps
module hex_float_operand_prep_tb_top;
    import hex_float_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_start = 1'b0;
    fop_e i_op = OP_NONE;
    logic i_single = 1'b0;
    logic [63:0] i_acc_a = 64'h4321_5678_9abc_def0;
    logic [63:0] i_acc_b = 64'h0;
    logic [31:0] i_fixed_acc = 32'h0000_5500;
    logic [31:0] i_status_wdata = 32'h0;
    logic [63:0] i_core_result = 64'h0;
    logic [6:0] i_core_exp = 7'h41;
    logic i_core_done = 1'b0;
    logic o_core_start, o_result_valid, o_fixed_valid, o_busy, o_true_zero_err;
    logic [63:0] o_core_mant_a, o_core_mant_b, o_result;
    logic [6:0] o_core_exp;
    logic [1:0] o_core_sign;
    logic [31:0] o_fixed_result, o_float_status;
    int errors = 0;
    int n_tests = 0;
    hex_float_operand_prep u_dut (.i_sys_clk, .i_sys_rst, .i_start, .i_op, .i_single, .i_acc_a,
        .i_acc_b, .i_fixed_acc, .i_status_wdata, .i_core_result, .i_core_exp, .i_core_done,
        .o_core_start, .o_core_mant_a, .o_core_mant_b, .o_core_exp, .o_core_sign,
        .o_result_valid, .o_result, .o_fixed_valid, .o_fixed_result, .o_float_status, .o_busy,
        .o_true_zero_err);
    initial begin
        forever #20 i_sys_clk = ~i_sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task stop_test;
        if (errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task tick;
        @(posedge i_sys_clk);
        #1;
    endtask
    task issue(input fop_e op, input logic sgl);
        i_op = op;
        i_single = sgl;
        i_start = 1'b1;
        tick();
        i_start = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_status(input logic rnd);
        i_status_wdata = rnd ? 32'h0080_0000 : 32'h0;
        issue(OP_LOAD_STATUS, 1'b0);
        tick();
        chk(o_float_status[23], rnd);
    endtask
    task t_direct;
        issue(OP_READ_HIGH, 1'b0);
        chk(o_fixed_valid, 1'b1);
        chk(o_fixed_result[15:0], 16'h4321);
        chk(o_true_zero_err, 1'b0);
        tick();
        issue(OP_LOAD_EXP, 1'b0);
        chk(o_result_valid, 1'b1);
        chk(o_result[62:56], 7'h55);
        tick();
        issue(OP_LOAD, 1'b1);
        chk(o_result, 64'h4321_5678_0000_0000);
        tick();
        issue(OP_STORE, 1'b0);
        chk(o_result, 64'h4321_5678_9abc_def0);
        tick();
        i_acc_a = 64'hc100_0000_0000_0000;
        issue(OP_LOAD, 1'b0);
        chk(o_true_zero_err, 1'b1);
        tick();
    endtask
    task t_arith(input fop_e op, input int lat, input logic [1:0] sgn, input logic [63:0] core,
            input logic [63:0] exp, input logic full);
        int n;
        i_acc_a = 64'h41ab_cdef_1111_1111;
        i_acc_b = 64'hc112_3456_2222_2222;
        issue(op, 1'b1);
        n = 0;
        while (o_core_start !== 1'b1 && n < 10) begin
            tick();
            n++;
        end
        if (n >= 10) begin
            errors++;
            stop_test();
        end
        // Launched after the n-th edge past the take, so seen high one edge later
        chk(n + 1, lat);
        chk(o_core_mant_a[63:40], 24'habcdef);
        chk(o_core_mant_a[39:0], 40'h0);
        chk(o_core_mant_b[63:40], 24'h123456);
        chk(o_core_exp, 7'h41);
        chk(o_core_sign, sgn);
        i_core_result = core;
        i_core_done = 1'b1;
        tick();
        i_core_done = 1'b0;
        n = 0;
        while (o_result_valid !== 1'b1 && n < 10) begin
            tick();
            n++;
        end
        if (n >= 10) begin
            errors++;
            stop_test();
        end
        chk(n + 1, 3);
        if (full) chk(o_result, exp);
        else chk(o_result[62:0], exp[62:0]);
        tick();
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge i_sys_clk);
        #1;
        i_sys_rst = 1'b0;
        chk(o_result, 64'h0);
        chk({61'h0, o_busy, o_core_start, o_result_valid}, 64'h0);
        t_status(1'b0);
        t_direct();
        t_arith(OP_ADD, 3, 2'b01, 64'h0abc_def9_0000_0000, 64'h40ab_cdef_0000_0000, 1'b0);
        t_status(1'b1);
        t_arith(OP_SUB, 3, 2'b00, 64'h0abc_def9_0000_0000, 64'h40ab_cdf0_0000_0000, 1'b0);
        t_arith(OP_MUL, 2, 2'b01, 64'habcd_ef12_0000_0000, 64'hc1ab_cdef_0000_0000, 1'b1);
        t_arith(OP_MUL, 2, 2'b01, 64'h0, 64'h0, 1'b1);
        t_arith(OP_MUL, 2, 2'b01, 64'habcd_ef80_0000_0000, 64'hc1ab_cdf0_0000_0000, 1'b1);
        t_arith(OP_MUL, 2, 2'b01, 64'hffff_ff90_0000_0000, 64'hc210_0000_0000_0000, 1'b1);
        stop_test();
    end
endmodule

// File: tb/hex_float_prep_props.sv
// Concurrent checks on the ports of the float operand preparation block
`timescale 1ns/1ps
module hex_float_prep_props
    import hex_float_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_start,
    input wire fop_e i_op,
    input wire logic i_single,
    input wire logic [63:0] i_acc_a,
    input wire logic [31:0] i_fixed_acc,
    input wire logic [31:0] i_status_wdata,
    input wire logic i_core_done,
    input wire logic o_core_start,
    input wire logic o_busy,
    input wire logic o_result_valid,
    input wire logic [63:0] o_result,
    input wire logic o_fixed_valid,
    input wire logic [31:0] o_fixed_result,
    input wire logic [31:0] o_float_status
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    logic take;
    logic arith_q;
    logic [63:0] acc_q;
    logic [31:0] fix_q;
    logic [31:0] wd_q;
    assign take = i_start && !o_busy;
    always_ff @(posedge i_sys_clk) begin
        acc_q <= i_acc_a;
        fix_q <= i_fixed_acc;
        wd_q <= i_status_wdata;
    end
    // Marks a pending arithmetic result, so pass-through moves are not judged as results
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || o_result_valid) begin
            arith_q <= 1'b0;
        end else if (take && i_op inside {OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_NORMALIZE}) begin
            arith_q <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    a_add_start_gap: assert property (
        take && (i_op == OP_ADD || i_op == OP_SUB) |-> ##3 o_core_start)
        else $error("core start late");
    a_mul_start_gap: assert property (
        take && (i_op == OP_MUL || i_op == OP_DIV) |-> ##2 o_core_start)
        else $error("core start late");
    a_arith_busy: assert property (
        take && i_op == OP_ADD |=> o_busy [*2])
        else $error("busy not held");
    a_done_to_valid: assert property (
        i_core_done |-> ##3 o_result_valid)
        else $error("result not stored");
    a_single_low_zero: assert property (
        o_result_valid && i_single |-> o_result[31:0] == 32'h0)
        else $error("low half not cleared");
    a_true_zero: assert property (
        o_result_valid && arith_q && o_result[55:0] == 56'h0 |-> o_result == 64'h0)
        else $error("zero not true zero");
    a_read_high: assert property (
        take && i_op == OP_READ_HIGH |=> o_fixed_valid && o_fixed_result[15:0] == acc_q[63:48])
        else $error("read high wrong");
    a_load_exp: assert property (
        take && i_op == OP_LOAD_EXP |=> o_result_valid && o_result[62:56] == fix_q[14:8])
        else $error("exponent load wrong");
    a_round_flag: assert property (
        take && i_op == OP_LOAD_STATUS |=> o_float_status[23] == wd_q[23])
        else $error("round flag not loaded");
endmodule
bind hex_float_operand_prep hex_float_prep_props u_props (.i_sys_clk, .i_sys_rst, .i_start, .i_op,
    .i_single, .i_acc_a, .i_fixed_acc, .i_status_wdata, .i_core_done, .o_core_start, .o_busy,
    .o_result_valid, .o_result, .o_fixed_valid, .o_fixed_result, .o_float_status);
